// [rxff_pkg.sv]
// Overview of operation
// - four address filters, each holding a programmable 48-bit MAC address
// - each filter selects comparison against source or destination address
// - per-byte mask bits exclude address bytes from the filter comparison
// - frames passing the filtering go to DMA memory, failing frames are dropped
// - four frame_type_match values, individually enabled, compared with the type field
// - optional destination address hash acceptance, enabled by configuration
// - while receiving, show which header field is on the external interface
// - pulse a strobe per parsed field; external logic latches the value then
package rxff_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_HASH_LO   = 8'h04;
    localparam logic [7:0] REG_HASH_HI   = 8'h08;
    localparam logic [7:0] REG_STAT      = 8'h0C;
    localparam logic [7:0] REG_ACC_CNT   = 8'h10;
    localparam logic [7:0] REG_DROP_CNT  = 8'h14;
    localparam logic [7:0] REG_ADDR_BASE = 8'h20;
    localparam logic [7:0] REG_TYPE_BASE = 8'h40;

    // control register fields
    localparam int CTRL_FILT_EN = 0;
    localparam int CTRL_HASH_EN = 1;
    localparam int CTRL_EXT_EN  = 2;
    localparam int CTRL_EXT_PRI = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // address-high and type register fields
    localparam int ADDRHI_MASK_LSB = 16;
    localparam int ADDRHI_EN       = 30;
    localparam int ADDRHI_SEL_SA   = 31;
    localparam int TYPE_EN         = 31;

    // header byte positions
    localparam logic [3:0] POS_DA_END   = 4'h5;
    localparam logic [3:0] POS_SA_END   = 4'hB;
    localparam logic [3:0] POS_TYPE_END = 4'hD;
    localparam logic [3:0] HDR_LEN      = 4'hE;
    localparam logic [3:0] CNT_MAX      = 4'hF;

    localparam int NUM_FILT = 4;
    localparam int NUM_TYPE = 4;

    typedef enum logic [2:0] {FLD_IDLE, FLD_DA, FLD_SA, FLD_TYPE, FLD_PAYLOAD} rxff_field_e;

    // one received byte with its framing
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rxff_byte_s;

    // per-frame decision toward DMA
    typedef struct packed {
        logic       valid;
        logic       accept;
        logic [1:0] queue;
    } rxff_verdict_s;

endpackage

// [rxff_hash.sv]
`timescale 1ns/1ns
// folds a 48-bit destination address into a 6-bit hash table index
module rxff_hash
    import rxff_pkg::*;
(
    // address in, index out
    input  wire logic [47:0] addr,
    output wire logic [5:0]  index
);

    genvar k;
    // each index bit is the xor of every sixth address bit
    generate
        for (k = 0; k < 6; k++) begin : g_fold
            assign index[k] = addr[k] ^ addr[k+6] ^ addr[k+12] ^ addr[k+18]
                            ^ addr[k+24] ^ addr[k+30] ^ addr[k+36] ^ addr[k+42];
        end
    endgenerate

endmodule

// [rxff_filter.sv]
`timescale 1ns/1ns
module rxff_filter
    import rxff_pkg::*;
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          sys_rst,
    // register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    // receive byte stream from the gigabit_mac
    input  wire rxff_byte_s    rx_in,
    // stream and decision toward DMA
    output rxff_byte_s         dma_out,
    output rxff_verdict_s      dma_verdict,
    // external fabric filter interface
    output rxff_field_e        ext_field,
    output logic [47:0]        ext_value,
    output logic               ext_strobe,
    input  wire logic          ext_accept,
    input  wire logic [1:0]    ext_queue
);

    // configuration and state registers
    logic [3:0]        ctrl_r;
    logic [63:0]       hash_tbl_r;
    logic [47:0]       filt_addr_r [NUM_FILT];
    logic [5:0]        filt_mask_r [NUM_FILT];
    logic              filt_en_r   [NUM_FILT];
    logic              filt_sa_r   [NUM_FILT];
    logic [15:0]       type_val_r  [NUM_TYPE];
    logic              type_en_r   [NUM_TYPE];
    logic [12:0]       stat_r;
    logic [31:0]       acc_cnt_r;
    logic [31:0]       drop_cnt_r;
    logic [3:0]        cnt_r;
    logic [47:0]       sh_r;
    logic [47:0]       da_r;
    logic [47:0]       sa_r;
    logic [15:0]       type_r;
    logic [31:0]       rdata_nxt;

    // parser wires
    logic [3:0]        cnt_cur;
    logic [3:0]        cnt_nxt;
    logic [47:0]       sh_nxt;
    rxff_field_e       fld_cur;
    logic              fld_done;
    logic [47:0]       fld_value;
    logic              frame_end;
    logic              hdr_ok;

    // decision wires
    logic [NUM_FILT-1:0] addr_hit;
    logic [NUM_TYPE-1:0] type_hit;
    logic [5:0]          hash_idx;
    logic                hash_hit;
    logic                int_pass;
    logic                ext_veto;
    logic                verdict_acc;
    logic [1:0]          verdict_q;

    // byte counter and field parsing
    assign cnt_cur   = rx_in.sof ? 4'h0 : cnt_r;
    assign cnt_nxt   = rx_in.eof ? 4'h0 : ((cnt_cur == CNT_MAX) ? CNT_MAX : cnt_cur + 4'h1);
    assign sh_nxt    = {sh_r[39:0], rx_in.data};
    assign fld_cur   = (cnt_cur <= POS_DA_END) ? FLD_DA :
                       (cnt_cur <= POS_SA_END) ? FLD_SA :
                       (cnt_cur <= POS_TYPE_END) ? FLD_TYPE : FLD_PAYLOAD;
    assign fld_done  = rx_in.valid && !rx_in.eof && (cnt_cur == POS_DA_END
                       || cnt_cur == POS_SA_END || cnt_cur == POS_TYPE_END);
    assign fld_value = (cnt_cur == POS_TYPE_END) ? {32'h0000_0000, sh_nxt[15:0]} : sh_nxt;
    assign frame_end = rx_in.valid && rx_in.eof;
    assign hdr_ok    = cnt_cur >= HDR_LEN;

    // address filters and type matchers
    genvar i, b;
    generate
        for (i = 0; i < NUM_FILT; i++) begin : g_filt
            logic [47:0] cmp_addr;
            logic [5:0]  byte_ok;
            assign cmp_addr = filt_sa_r[i] ? sa_r : da_r;
            for (b = 0; b < 6; b++) begin : g_byte
                // masked bytes always agree
                assign byte_ok[b] = filt_mask_r[i][b]
                                    || cmp_addr[47-8*b -: 8] == filt_addr_r[i][47-8*b -: 8];
            end
            assign addr_hit[i] = filt_en_r[i] && &byte_ok;
            assign type_hit[i] = type_en_r[i] && type_val_r[i] == type_r;
        end
    endgenerate

    // hash of the destination address
    rxff_hash u_hash (
        .addr  (da_r),
        .index (hash_idx)
    );
    assign hash_hit = ctrl_r[CTRL_HASH_EN] && hash_tbl_r[hash_idx];

    // final frame decision, external answer sampled at frame end
    assign int_pass    = !ctrl_r[CTRL_FILT_EN] || |addr_hit || |type_hit || hash_hit;
    assign ext_veto    = ctrl_r[CTRL_EXT_EN] && !ctrl_r[CTRL_EXT_PRI] && !ext_accept;
    assign verdict_acc = hdr_ok && int_pass && !ext_veto;
    assign verdict_q   = (ctrl_r[CTRL_EXT_EN] && ctrl_r[CTRL_EXT_PRI]) ? ext_queue : 2'h0;

    // header capture
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_r  <= 4'h0;
            sh_r   <= 48'h0000_0000_0000;
            da_r   <= 48'h0000_0000_0000;
            sa_r   <= 48'h0000_0000_0000;
            type_r <= 16'h0000;
        end else if (rx_in.valid) begin
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            if (cnt_cur == POS_DA_END) da_r <= sh_nxt;
            if (cnt_cur == POS_SA_END) sa_r <= sh_nxt;
            if (cnt_cur == POS_TYPE_END) type_r <= sh_nxt[15:0];
        end
    end

    // external field indication and strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_field  <= FLD_IDLE;
            ext_value  <= 48'h0000_0000_0000;
            ext_strobe <= 1'b0;
        end else begin
            ext_strobe <= fld_done;
            if (fld_done) ext_value <= fld_value;
            if (rx_in.valid) ext_field <= rx_in.eof ? FLD_IDLE : fld_cur;
        end
    end

    // stream and verdict toward DMA
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dma_out     <= '0;
            dma_verdict <= '0;
        end else begin
            dma_out            <= rx_in;
            dma_verdict.valid  <= frame_end;
            if (frame_end) begin
                dma_verdict.accept <= verdict_acc;
                dma_verdict.queue  <= verdict_q;
            end
        end
    end

    // frame statistics
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_r     <= 13'h0000;
            acc_cnt_r  <= 32'h0000_0000;
            drop_cnt_r <= 32'h0000_0000;
        end else if (frame_end) begin
            stat_r <= {verdict_acc, verdict_q, ext_accept, hash_hit, type_hit, addr_hit};
            if (verdict_acc) acc_cnt_r <= acc_cnt_r + 32'h0000_0001;
            else drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
        end
    end

    // register write decode
    logic wr_ctrl;
    logic wr_hlo;
    logic wr_hhi;
    assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    assign wr_hlo  = reg_wr && reg_addr == REG_HASH_LO;
    assign wr_hhi  = reg_wr && reg_addr == REG_HASH_HI;

    // global configuration
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r     <= CTRL_RST;
            hash_tbl_r <= 64'h0000_0000_0000_0000;
        end else begin
            if (wr_ctrl) ctrl_r <= reg_wdata[3:0];
            if (wr_hlo) hash_tbl_r[31:0] <= reg_wdata;
            if (wr_hhi) hash_tbl_r[63:32] <= reg_wdata;
        end
    end

    // per-filter and per-type configuration
    generate
        for (i = 0; i < NUM_FILT; i++) begin : g_cfg
            logic wr_lo;
            logic wr_hi;
            logic wr_ty;
            assign wr_lo = reg_wr && reg_addr == REG_ADDR_BASE + 8'(8 * i);
            assign wr_hi = reg_wr && reg_addr == REG_ADDR_BASE + 8'(8 * i + 4);
            assign wr_ty = reg_wr && reg_addr == REG_TYPE_BASE + 8'(4 * i);
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    filt_addr_r[i] <= 48'h0000_0000_0000;
                    filt_mask_r[i] <= 6'h00;
                    filt_en_r[i]   <= 1'b0;
                    filt_sa_r[i]   <= 1'b0;
                    type_val_r[i]  <= 16'h0000;
                    type_en_r[i]   <= 1'b0;
                end else begin
                    if (wr_lo) filt_addr_r[i][31:0] <= reg_wdata;
                    if (wr_hi) begin
                        filt_addr_r[i][47:32] <= reg_wdata[15:0];
                        filt_mask_r[i]        <= reg_wdata[ADDRHI_MASK_LSB +: 6];
                        filt_en_r[i]          <= reg_wdata[ADDRHI_EN];
                        filt_sa_r[i]          <= reg_wdata[ADDRHI_SEL_SA];
                    end
                    if (wr_ty) begin
                        type_val_r[i] <= reg_wdata[15:0];
                        type_en_r[i]  <= reg_wdata[TYPE_EN];
                    end
                end
            end
        end
    endgenerate

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (reg_addr)
            REG_CTRL:     rdata_nxt = {28'h000_0000, ctrl_r};
            REG_HASH_LO:  rdata_nxt = hash_tbl_r[31:0];
            REG_HASH_HI:  rdata_nxt = hash_tbl_r[63:32];
            REG_STAT:     rdata_nxt = {19'h0_0000, stat_r};
            REG_ACC_CNT:  rdata_nxt = acc_cnt_r;
            REG_DROP_CNT: rdata_nxt = drop_cnt_r;
            default: begin
                for (int n = 0; n < NUM_FILT; n++) begin
                    if (reg_addr == REG_ADDR_BASE + 8'(8 * n))
                        rdata_nxt = filt_addr_r[n][31:0];
                    if (reg_addr == REG_ADDR_BASE + 8'(8 * n + 4))
                        rdata_nxt = {filt_sa_r[n], filt_en_r[n], 8'h00, filt_mask_r[n], filt_addr_r[n][47:32]};
                    if (reg_addr == REG_TYPE_BASE + 8'(4 * n))
                        rdata_nxt = {type_en_r[n], 15'h0000, type_val_r[n]};
                end
            end
        endcase
    end

    // read data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) reg_rdata <= 32'h0000_0000;
        else if (reg_rd) reg_rdata <= rdata_nxt;
        else reg_rdata <= 32'h0000_0000;
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_DA_STROBE: assert property (
        rx_in.valid && !rx_in.eof && cnt_cur == POS_DA_END
        |=> ext_strobe && ext_field == FLD_DA && ext_value == $past(sh_nxt))
        else $error("destination address strobe wrong");
    AST_FIELD_TYPE: assert property (
        rx_in.valid && !rx_in.eof && cnt_cur > POS_SA_END && cnt_cur <= POS_TYPE_END
        |=> ext_field == FLD_TYPE)
        else $error("type field not indicated");
    AST_RUNT_DROP: assert property (
        frame_end && !hdr_ok |=> dma_verdict.valid && !dma_verdict.accept)
        else $error("short frame not dropped");
    AST_FILTER_DROP: assert property (
        frame_end && ctrl_r[CTRL_FILT_EN] && !(|addr_hit) && !(|type_hit) && !hash_hit
        |=> !dma_verdict.accept)
        else $error("unmatched frame passed");
    AST_ADDR_EXACT: assert property (
        filt_en_r[0] && filt_mask_r[0] == 6'h00 && filt_addr_r[0] == (filt_sa_r[0] ? sa_r : da_r)
        |-> addr_hit[0])
        else $error("address filter missed exact match");
    AST_ADDR_MASKALL: assert property (
        filt_en_r[1] && filt_mask_r[1] == 6'h3F |-> addr_hit[1])
        else $error("fully masked filter did not match");
    AST_TYPE_MATCH: assert property (
        type_hit[2] |-> type_en_r[2] && type_val_r[2] == type_r)
        else $error("type match without enable or equality");
    AST_HASH_OFF: assert property (
        !ctrl_r[CTRL_HASH_EN] |-> !hash_hit)
        else $error("hash hit while disabled");
    AST_EXT_VETO: assert property (
        frame_end && ctrl_r[CTRL_EXT_EN] && !ctrl_r[CTRL_EXT_PRI] && !ext_accept
        |=> dma_verdict.valid && !dma_verdict.accept)
        else $error("external reject ignored");
    AST_EXT_QUEUE: assert property (
        frame_end && ctrl_r[CTRL_EXT_EN] && ctrl_r[CTRL_EXT_PRI]
        |=> dma_verdict.queue == $past(ext_queue))
        else $error("external queue not applied");

endmodule

// [rxff_fabric.sv]
`timescale 1ns/1ns
// fabric stand-in: latches the type field on its strobe and decides on it combinationally
module rxff_fabric
    import rxff_pkg::*;
#(
    parameter logic [15:0] REJ_TYPE = 16'h9999
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // field feed from the filter
    input  wire rxff_field_e ext_field,
    input  wire logic [47:0] ext_value,
    input  wire logic        ext_strobe,
    // decision back to the filter
    output logic             ext_accept,
    output logic [1:0]       ext_queue
);
    logic [15:0] type_r;

    // capture the type field only when it is strobed
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            type_r <= 16'h0000;
        end else if (ext_strobe && ext_field == FLD_TYPE) begin
            type_r <= ext_value[15:0];
        end
    end

    // verdict from latched fields only, no clock in the path
    assign ext_accept = (type_r != REJ_TYPE);
    assign ext_queue  = type_r[1:0];
endmodule

// [test_rx_frame_filter.sv]
`timescale 1ns/1ns
module test_rx_frame_filter;
    import rxff_pkg::*;
    localparam logic [47:0] DA_A = 48'h0200_0000_0001;
    localparam logic [47:0] SA_B = 48'h0200_0000_0002;
    localparam logic [47:0] DA_C = 48'h0200_0000_0003;
    localparam logic [47:0] DA_H = 48'h0200_0000_0055;
    localparam logic [47:0] DA_X = 48'h0200_0000_00AA;
    localparam logic [47:0] SA_X = 48'h0200_0000_00BB;
    localparam logic [15:0] TY_X = 16'h88B5;

    logic          clock;
    logic          sys_rst;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [31:0]   reg_rdata;
    rxff_byte_s    rx_in;
    rxff_byte_s    dma_out;
    rxff_verdict_s dma_verdict;
    rxff_field_e   ext_field;
    logic [47:0]   ext_value;
    logic          ext_strobe;
    logic          ext_accept;
    logic [1:0]    ext_queue;
    int            bad_count;
    int            checks_done;
    int            n_acc;
    int            n_drop;
    int            sk;
    logic [47:0]   cur_da;
    logic [47:0]   cur_sa;
    logic [15:0]   cur_typ;
    logic [31:0]   rv;
    logic [5:0]    h;

    rxff_filter DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in), .dma_out(dma_out),
        .dma_verdict(dma_verdict), .ext_field(ext_field), .ext_value(ext_value), .ext_strobe(ext_strobe),
        .ext_accept(ext_accept), .ext_queue(ext_queue));
    rxff_fabric u_fab (.clock(clock), .sys_rst(sys_rst), .ext_field(ext_field), .ext_value(ext_value),
        .ext_strobe(ext_strobe), .ext_accept(ext_accept), .ext_queue(ext_queue));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // compare and count
    task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task done(input string nm);
        $display("test %s finished", nm);
    endtask

    // register port cycles
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    // six-bit fold of the destination address
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int m = 0; m < 8; m++) r = r ^ a[6*m +: 6];
        return r;
    endfunction

    // send one frame, then check its verdict
    task frame(input logic [47:0] da, input logic [47:0] sa, input logic [15:0] typ, input int len,
               input logic acc, input logic [1:0] q);
        logic [111:0] hdr;
        logic [7:0]   last;
        int           n;
        hdr     = {da, sa, typ};
        cur_da  = da;
        cur_sa  = sa;
        cur_typ = typ;
        sk      = 0;
        for (int i = 0; i < len; i++) begin
            @(posedge clock);
            rx_in <= '{valid: 1'b1, sof: (i == 0), eof: (i == len - 1),
                       data: (i < 14) ? hdr[111 - 8*i -: 8] : 8'(i)};
        end
        @(posedge clock);
        rx_in <= '0;
        #1;
        // the eof byte stands on the DMA side one cycle after it was driven onto rx_in
        last = (len < 15) ? hdr[111 - 8*(len-1) -: 8] : 8'(len - 1);
        chk("dma last byte", {dma_out.valid, dma_out.eof, dma_out.data}, {2'b11, last});
        for (n = 0; n < 8 && dma_verdict.valid !== 1'b1; n++) @(posedge clock) #1;
        if (n == 8) begin
            bad_count++;
            give_verdict;
        end
        chk("accept", dma_verdict.accept, acc);
        chk("queue", dma_verdict.queue, q);
        chk("field after frame", ext_field, FLD_IDLE);
        if (acc) n_acc++;
        else n_drop++;
    endtask

    // every strobe must carry the next header field in order
    always @(posedge clock) begin
        if (ext_strobe === 1'b1) begin
            chk("field kind", ext_field, sk == 0 ? FLD_DA : sk == 1 ? FLD_SA : FLD_TYPE);
            chk("field value", ext_value, sk == 0 ? cur_da : sk == 1 ? cur_sa : {32'h0000_0000, cur_typ});
            sk++;
        end
    end

    // hang guard
    initial begin
        #500_000;
        bad_count++;
        give_verdict;
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_in = '0;
        bad_count = 0;
        checks_done = 0;
        n_acc = 0;
        n_drop = 0;
        sk = 0;
        cur_da = '0;
        cur_sa = '0;
        cur_typ = '0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(REG_CTRL);
        chk("ctrl reset", rv, 48'h0);
        rd(8'hFC);
        chk("unmapped", rv, 48'h0);
        frame(DA_X, SA_X, TY_X, 16, 1'b1, 2'd0);
        wr(REG_CTRL, 32'h0000_0001);
        frame(DA_A, SA_X, TY_X, 16, 1'b0, 2'd0);
        done("accept and drop");
        wr(REG_ADDR_BASE, DA_A[31:0]);
        wr(REG_ADDR_BASE + 8'h04, {2'b01, 8'h00, 6'h00, DA_A[47:32]});
        rd(REG_ADDR_BASE + 8'h04);
        chk("addr hi", rv, {16'h0000, 2'b01, 8'h00, 6'h00, DA_A[47:32]});
        frame(DA_A, SA_X, TY_X, 16, 1'b1, 2'd0);
        wr(REG_ADDR_BASE + 8'h18, SA_B[31:0]);
        wr(REG_ADDR_BASE + 8'h1C, {2'b11, 8'h00, 6'h00, SA_B[47:32]});
        frame(DA_X, SA_B, TY_X, 16, 1'b1, 2'd0);
        frame(SA_B, SA_X, TY_X, 16, 1'b0, 2'd0);
        wr(REG_ADDR_BASE + 8'h08, DA_C[31:0]);
        wr(REG_ADDR_BASE + 8'h0C, {2'b01, 8'h00, 6'h20, DA_C[47:32]});
        frame(DA_C ^ 48'h0000_0000_00FF, SA_X, TY_X, 16, 1'b1, 2'd0);
        frame(DA_C ^ 48'h0000_0000_0100, SA_X, TY_X, 16, 1'b0, 2'd0);
        // fully masked filter matches anything, then it is switched off again
        wr(REG_ADDR_BASE + 8'h0C, {2'b01, 8'h00, 6'h3F, 16'h0000});
        frame(DA_X, SA_X, TY_X, 16, 1'b1, 2'd0);
        wr(REG_ADDR_BASE + 8'h0C, 32'h0000_0000);
        frame(DA_X, SA_X, TY_X, 16, 1'b0, 2'd0);
        done("address filters");
        for (int j = 0; j < 4; j++) begin
            wr(REG_TYPE_BASE + 8'(4*j), {1'b1, 15'h0000, 16'h0800 + 16'(j)});
            frame(DA_X, SA_X, 16'h0800 + 16'(j), 16, 1'b1, 2'd0);
            wr(REG_TYPE_BASE + 8'(4*j), {1'b0, 15'h0000, 16'h0800 + 16'(j)});
            frame(DA_X, SA_X, 16'h0800 + 16'(j), 16, 1'b0, 2'd0);
        end
        done("type match");
        h = hidx(DA_H);
        wr(h[5] ? REG_HASH_HI : REG_HASH_LO, 32'h0000_0001 << h[4:0]);
        wr(REG_CTRL, 32'h0000_0003);
        frame(DA_H, SA_X, TY_X, 16, 1'b1, 2'd0);
        wr(REG_CTRL, 32'h0000_0001);
        frame(DA_H, SA_X, TY_X, 16, 1'b0, 2'd0);
        done("hash");
        wr(REG_CTRL, 32'h0000_0000);
        frame(DA_X, SA_X, TY_X, 10, 1'b0, 2'd0);
        wr(REG_CTRL, 32'h0000_0004);
        frame(DA_X, SA_X, 16'h9999, 16, 1'b0, 2'd0);
        frame(DA_X, SA_X, TY_X, 16, 1'b1, 2'd0);
        wr(REG_CTRL, 32'h0000_000C);
        for (int q = 0; q < 4; q++) begin
            frame(DA_X, SA_X, 16'h8000 + 16'(q), 16, 1'b1, 2'(q));
        end
        done("external decision");
        rd(REG_ACC_CNT);
        chk("accepted count", rv, 48'(n_acc));
        rd(REG_DROP_CNT);
        chk("dropped count", rv, 48'(n_drop));
        rd(REG_STAT);
        chk("last status", rv, 48'h0000_0000_1E00);
        done("statistics");
        give_verdict;
    end
endmodule
